/* fpc_pkg.sv */
`default_nettype none
package fpc_pkg;
	// ==========================================================
	// flash control register field positions
	localparam int CTL_WIDTH = 8;
	localparam int CTL_PROG = 0;
	localparam int CTL_ERASE = 1;
	localparam int CTL_PVER = 2;
	localparam int CTL_EVER = 3;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// ==========================================================
	// block select registers
	localparam int BLK_WIDTH = 8;
	localparam logic [7:0] BLK_RESET = 8'h00;
	// ==========================================================
	// wait-state control register overlay bits
	localparam int OVL_HI = 7;
	localparam int OVL_LO = 6;
	localparam logic [7:0] WSC_RESET = 8'h08;
	// ==========================================================
	// cell array operation modes
	typedef enum logic [2:0] {
		FPC_IDLE,
		FPC_PROG,
		FPC_ERASE,
		FPC_PVERIFY,
		FPC_EVERIFY,
		FPC_PREWRITE
	} fpc_mode_t;
endpackage
`default_nettype wire

/* fpc_flash_ctrl.sv */
// Summary of operation
// - control bits 3:0 all zero gives prewrite-verify
// - software protection blocks program and erase
// - unselected blocks protected; verify still allowed
// - one overlay bit set blocks program/erase
// - overlay protection disables erase for all blocks
// - no 12 V clears control and selects
// - reset or standby clears control and selects
// - interrupt aborts program or erase immediately
// - abort keeps registers, verify stays usable
// - abort protection lasts until reset only
// - overlay bits 7,6; kept in software standby
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_ctrl
	import fpc_pkg::*;
#(
	parameter int NBLK = 16
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic programVoltageOk,
	input wire logic standbyEnter,
	input wire logic hwStandby,
	input wire logic irqIn,
	input wire logic ctlWrite,
	input wire logic [fpc_pkg::CTL_WIDTH-1:0] ctlWdata,
	input wire logic blkAWrite,
	input wire logic blkBWrite,
	input wire logic [fpc_pkg::BLK_WIDTH-1:0] blkWdata,
	input wire logic wscWrite,
	input wire logic [7:0] wscWdata,
	input wire logic [$clog2(NBLK)-1:0] blkAddr,
	output logic [fpc_pkg::CTL_WIDTH-1:0] flashControlReg,
	output logic [fpc_pkg::BLK_WIDTH-1:0] blockSelectRegA,
	output logic [fpc_pkg::BLK_WIDTH-1:0] blockSelectRegB,
	output logic [7:0] waitStateControlReg,
	output logic progPulse,
	output logic erasePulse,
	output logic pverifyOn,
	output logic everifyOn,
	output logic prewriteVerifyOn,
	output logic abortLatched
);
	import fpc_pkg::*;

	// ==========================================================
	// reset synchroniser
	logic rstSync1_r, rstSync2_r;
	wire logic srstn = rstSync2_r;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rstSync1_r <= 1'b0;
			rstSync2_r <= 1'b0;
		end
		else
		begin
			rstSync1_r <= 1'b1;
			rstSync2_r <= rstSync1_r;
		end
	end

	// ==========================================================
	// protection decode
	logic [15:0] blkSel;
	logic ovlProtect, blkEnabled, pgmAllowed, eraseAllowed, clearRegs;
	assign blkSel = {blockSelectRegA, blockSelectRegB};
	assign ovlProtect = waitStateControlReg[OVL_HI] ^ waitStateControlReg[OVL_LO];
	assign blkEnabled = blkSel[blkAddr[3:0]];
	// continuous checks; a set bit under protection yields no pulse
	assign pgmAllowed = blkEnabled && !ovlProtect && !abortLatched && !irqIn;
	assign eraseAllowed = (blkSel != 16'h0000) && !ovlProtect
		&& !abortLatched && !irqIn;
	assign clearRegs = !programVoltageOk || standbyEnter || hwStandby;

	// ==========================================================
	// control and block select registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			flashControlReg <= CTL_RESET;
			blockSelectRegA <= BLK_RESET;
			blockSelectRegB <= BLK_RESET;
		end
		else if (!srstn || clearRegs)
		begin
			flashControlReg <= CTL_RESET;
			blockSelectRegA <= BLK_RESET;
			blockSelectRegB <= BLK_RESET;
		end
		else
		begin
			// contents kept after abort
			if (ctlWrite)
				flashControlReg <= ctlWdata;
			if (blkAWrite)
				blockSelectRegA <= blkWdata;
			if (blkBWrite)
				blockSelectRegB <= blkWdata;
		end
	end

	// ==========================================================
	// overlay bits: cleared by reset and hardware standby only
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			waitStateControlReg <= WSC_RESET;
		else if (!srstn || hwStandby)
			waitStateControlReg <= WSC_RESET;
		else if (wscWrite)
			waitStateControlReg <= wscWdata;
	end

	// ==========================================================
	// sticky abort on interrupt during program or erase
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			abortLatched <= 1'b0;
		else if (!srstn)
			abortLatched <= 1'b0;
		else if (irqIn && (progPulse || erasePulse))
			abortLatched <= 1'b1;
	end

	// ==========================================================
	// pulse and verify outputs
	logic progNxt, eraseNxt, verOk;
	assign verOk = programVoltageOk && !clearRegs;
	always_comb
	begin
		progNxt = flashControlReg[CTL_PROG] && pgmAllowed && verOk;
		eraseNxt = flashControlReg[CTL_ERASE] && !flashControlReg[CTL_PROG]
			&& eraseAllowed && verOk;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			progPulse <= 1'b0;
			erasePulse <= 1'b0;
			pverifyOn <= 1'b0;
			everifyOn <= 1'b0;
			prewriteVerifyOn <= 1'b0;
		end
		else if (!srstn)
		begin
			progPulse <= 1'b0;
			erasePulse <= 1'b0;
			pverifyOn <= 1'b0;
			everifyOn <= 1'b0;
			prewriteVerifyOn <= 1'b0;
		end
		else
		begin
			progPulse <= progNxt;
			erasePulse <= eraseNxt;
			pverifyOn <= verOk && flashControlReg[CTL_PVER];
			everifyOn <= verOk && flashControlReg[CTL_EVER];
			prewriteVerifyOn <= verOk && (flashControlReg[3:0] == 4'h0);
		end
	end

	// ==========================================================
	// checks
	a_irq_stops_pulse: assert property (@(posedge clk) disable iff (!srstn)
		irqIn |=> !progPulse && !erasePulse)
		else $error("pulse seen after interrupt");
	a_abort_sticky: assert property (@(posedge clk) disable iff (!srstn)
		abortLatched |=> abortLatched)
		else $error("abort state cleared without reset");
	a_abort_no_pulse: assert property (@(posedge clk) disable iff (!srstn)
		$past(abortLatched) |-> !progPulse && !erasePulse)
		else $error("pulse while aborted");
	a_abort_sets: assert property (@(posedge clk) disable iff (!srstn)
		irqIn && (progPulse || erasePulse) |=> abortLatched)
		else $error("abort not latched");
	a_vpp_clears: assert property (@(posedge clk) disable iff (!srstn)
		!programVoltageOk |=> flashControlReg == CTL_RESET && blockSelectRegA == BLK_RESET
			&& blockSelectRegB == BLK_RESET)
		else $error("registers kept without program voltage");
	a_standby_clears: assert property (@(posedge clk) disable iff (!srstn)
		standbyEnter |=> flashControlReg == CTL_RESET ##1 !progPulse && !erasePulse)
		else $error("standby did not clear");
	a_ovl_protect: assert property (@(posedge clk) disable iff (!srstn)
		$past(ovlProtect) |-> !progPulse && !erasePulse)
		else $error("pulse under overlay protection");
	a_blk_protect: assert property (@(posedge clk) disable iff (!srstn)
		$past(blkSel == 16'h0000) |-> !progPulse && !erasePulse)
		else $error("pulse with no block selected");
	a_prewrite: assert property (@(posedge clk) disable iff (!srstn)
		srstn && verOk && flashControlReg[3:0] == 4'h0 |=> prewriteVerifyOn)
		else $error("prewrite verify not entered");
	a_blk_prog: assert property (@(posedge clk) disable iff (!srstn)
		progPulse |-> $past(flashControlReg[CTL_PROG] && blkEnabled))
		else $error("program pulse without enable");
	c_program: cover property (@(posedge clk) disable iff (!srstn) progPulse);
	c_erase: cover property (@(posedge clk) disable iff (!srstn) erasePulse);
	c_abort: cover property (@(posedge clk) disable iff (!srstn) $rose(abortLatched));
	c_verify_after_abort: cover property (@(posedge clk) disable iff (!srstn)
		abortLatched && pverifyOn);
endmodule // fpc_flash_ctrl
`default_nettype wire

/* fpc_flash_array.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// cell array and programming voltage pin stand-in
module fpc_flash_array
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic vppOn,
	input wire logic progPulse,
	input wire logic erasePulse,
	output logic programVoltageOk,
	output logic [15:0] pulseCycles
);
	// 12 V present only while the bench asks for it
	assign programVoltageOk = vppOn;
	// cycles of pulse seen since reset, for total-time budgeting
	always_ff @(posedge clk)
	begin
		if (!rstn)
			pulseCycles <= 16'h0000;
		else if (progPulse || erasePulse)
			pulseCycles <= pulseCycles + 16'h0001;
	end
endmodule // fpc_flash_array
`default_nettype wire

/* flash_program_erase_protect_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_protect_control_test;
	import fpc_pkg::*;
	logic clk = 0, rstn = 0, vppOn = 1, standbyEnter = 0, hwStandby = 0, irqIn = 0;
	logic ctlWrite = 0, blkAWrite = 0, blkBWrite = 0, wscWrite = 0, programVoltageOk;
	logic [7:0] ctlWdata = 8'h00, blkWdata = 8'h00, wscWdata = 8'h00;
	logic [3:0] blkAddr = 4'h0;
	logic [7:0] fcr, bsa, bsb, wsc;
	logic pp, ep, pv, ev, pw, ab;
	logic [15:0] pulseCycles;
	int mismatches = 0, nChecks = 0;
	// verify setup wait, 4 us of 25 ns cycles
	localparam int VSETUP = 160;
	// ==========================================================
	// clock, reset, watchdog
	initial forever #12.5 clk = ~clk;
	initial
	begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
	end
	initial
	begin
		repeat (3000) @(posedge clk);
		mismatches++;
		giveVerdict();
	end
	fpc_flash_array i_arr (.clk(clk), .rstn(rstn), .vppOn(vppOn), .progPulse(pp), .erasePulse(ep),
		.programVoltageOk(programVoltageOk), .pulseCycles(pulseCycles));
	fpc_flash_ctrl #(.NBLK(16)) i_dut (.clk(clk), .rstn(rstn),
		.programVoltageOk(programVoltageOk), .standbyEnter(standbyEnter),
		.hwStandby(hwStandby), .irqIn(irqIn), .ctlWrite(ctlWrite), .ctlWdata(ctlWdata),
		.blkAWrite(blkAWrite), .blkBWrite(blkBWrite), .blkWdata(blkWdata),
		.wscWrite(wscWrite), .wscWdata(wscWdata), .blkAddr(blkAddr),
		.flashControlReg(fcr), .blockSelectRegA(bsa), .blockSelectRegB(bsb),
		.waitStateControlReg(wsc), .progPulse(pp), .erasePulse(ep), .pverifyOn(pv),
		.everifyOn(ev), .prewriteVerifyOn(pw), .abortLatched(ab));
	// ==========================================================
	// shared tasks
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		nChecks++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// sel 0 control, 1 select a, 2 select b, 3 wait-state
	task automatic wr(input int sel, input logic [7:0] d);
		@(posedge clk);
		ctlWrite <= (sel == 0);
		blkAWrite <= (sel == 1);
		blkBWrite <= (sel == 2);
		wscWrite <= (sel == 3);
		{ctlWdata, blkWdata, wscWdata} <= {d, d, d};
		@(posedge clk);
		{ctlWrite, blkAWrite, blkBWrite, wscWrite} <= 4'h0;
		step(0);
	endtask
	// sel 0 interrupt, 1 software standby, 2 hardware standby
	task automatic pulseIn(input int sel);
		@(posedge clk);
		irqIn <= (sel == 0);
		standbyEnter <= (sel == 1);
		hwStandby <= (sel == 2);
		@(posedge clk);
		{irqIn, standbyEnter, hwStandby} <= 3'h0;
		step(0);
	endtask
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	// cell data, pulse lengths
	// retries and guard timer stay with software; bench pulses are short, never retried
	task automatic tBlockAbort();
		chk("ctl", 8'h00, fcr);
		chk("wsc", 8'h08, wsc);
		wr(0, 8'h01);
		step(1);
		chk("prog", 8'h00, {7'h0, pp});
		wr(0, 8'h00);
		step(VSETUP);
		chk("prewrite", 8'h01, {7'h0, pw});
		wr(1, 8'h80);
		wr(2, 8'h01);
		wr(0, 8'h01);
		step(1);
		chk("prog", 8'h01, {7'h0, pp});
		pulseIn(0);
		chk("prog", 8'h00, {7'h0, pp});
		chk("abort", 8'h01, {7'h0, ab});
		chk("ctl", 8'h01, fcr);
		chk("sela", 8'h80, bsa);
		chk("pulses", 8'h02, pulseCycles[7:0]);
		wr(0, 8'h04);
		step(VSETUP);
		chk("pverify", 8'h01, {7'h0, pv});
		wr(0, 8'h08);
		step(VSETUP);
		chk("everify", 8'h01, {7'h0, ev});
		wr(0, 8'h01);
		step(1);
		chk("prog", 8'h00, {7'h0, pp});
		$display("block and abort test done");
	endtask
	task automatic tOverlayClear();
		wr(2, 8'h01);
		wr(3, 8'h40);
		wr(0, 8'h02);
		step(1);
		chk("erase", 8'h00, {7'h0, ep});
		wr(3, 8'hc0);
		step(1);
		chk("erase", 8'h01, {7'h0, ep});
		vppOn <= 1'b0;
		step(2);
		chk("selb", 8'h00, bsb);
		vppOn <= 1'b1;
		wr(2, 8'h01);
		pulseIn(1);
		step(1);
		chk("selb", 8'h00, bsb);
		chk("wsc", 8'hc0, wsc);
		pulseIn(2);
		step(1);
		chk("wsc", 8'h08, wsc);
		chk("pulses", 8'h01, pulseCycles[7:0]);
		$display("overlay and clear test done");
	endtask
	// main sequence with a mid-run reset
	initial
	begin
		step(6);
		tBlockAbort();
		rstn <= 1'b0;
		step(10);
		rstn <= 1'b1;
		step(4);
		chk("abort", 8'h00, {7'h0, ab});
		chk("sela", 8'h00, bsa);
		tOverlayClear();
		giveVerdict();
	end
endmodule // flash_program_erase_protect_control_test
`default_nettype wire
